// ### hdl/dos_pkg.sv
// package: constants, register map and carrier types of the directional
// overcurrent supervision block
// assumes: 10 MHz hclk, one AHB-Lite slave, element magnitudes in a common unit
package dos_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int N_ELEM = 19;
    localparam int N_INST = 10;
    localparam int N_UNIT = 4;
    localparam int MAG_W  = 16;
    localparam int MS_W   = 16;
    localparam int ACC_W  = 40;

    // element index map: 0..2 phase inst, 3..5 ground inst, 6..8 negseq inst,
    // 9 polarization-channel inst, 10..12 phase timed, 13..15 ground timed,
    // 16..18 negseq timed
    localparam int U_PHASE  = 0;
    localparam int U_GROUND = 1;
    localparam int U_NEGSEQ = 2;
    localparam int U_POSSEQ = 3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    // zero-delay elements operate between 20 ms and 25 ms
    localparam int MIN_OP_MS     = 22;

    // pickup at setting + setting/16 (1.0625), drop-out below setting (1.00)
    localparam int PU_SHIFT = 4;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_COORD    = 12'h004;
    localparam logic [11:0] ADDR_PICKUP   = 12'h008;
    localparam logic [11:0] ADDR_TRIP     = 12'h00C;
    localparam logic [11:0] ADDR_DIR      = 12'h010;
    localparam logic [11:0] ADDR_SET_BASE = 12'h100;
    localparam logic [11:0] ADDR_DLY_BASE = 12'h180;

    localparam int TORQUE_W    = 2;
    localparam int DLY_INV_BIT = 16;

    localparam logic [1:0]  TORQUE_OFF = 2'h0;
    localparam logic [1:0]  TORQUE_FWD = 2'h1;
    localparam logic [1:0]  TORQUE_REV = 2'h2;

    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] COORD_RST = 16'h0000;
    localparam logic [15:0] SET_RST   = 16'hFFFF;
    localparam logic [16:0] DLY_RST   = 17'h00000;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic fwd;
        logic rev;
    } dos_meas_t;

    typedef struct packed {
        logic fwd_inst;
        logic rev_inst;
        logic fwd_timed;
        logic rev_timed;
    } dos_dir_t;

    typedef struct packed {
        logic negseq_timed3_enable;
        logic ground_timed3_enable;
        logic phase_timed3_enable;
        logic negseq_timed2_enable;
        logic ground_timed2_enable;
        logic phase_timed2_enable;
        logic negseq_timed1_enable;
        logic ground_timed1_enable;
        logic phase_timed1_enable;
        logic polchan_inst_enable;
        logic negseq_inst3_enable;
        logic negseq_inst2_enable;
        logic negseq_inst1_enable;
        logic ground_inst3_enable;
        logic ground_inst2_enable;
        logic ground_inst1_enable;
        logic phase_inst3_enable;
        logic phase_inst2_enable;
        logic phase_inst1_enable;
    } dos_enables_t;

endpackage

// ### hdl/dos_dir_unit.sv
// directional unit: turns measured direction into instantaneous and
// coordination-delayed permissions for its overcurrent elements
// assumes: direction flags and control levels come from logic on hclk
`timescale 1ns/1ps
`default_nettype none
module dos_dir_unit
    import dos_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ms_tick,
    input  wire logic [1:0]          torque,
    input  wire dos_meas_t           meas,
    input  wire logic                reverse_in,
    input  wire logic                nondir_in,
    input  wire logic [MS_W-1:0]     coord_ms,
    output dos_dir_t                 dir,
    output logic                     perm_inst,
    output logic                     perm_timed
);

    // ****************************************************************
    // direction after reversal
    // ****************************************************************
    wire logic eff_fwd = reverse_in ? meas.rev : meas.fwd; // [R09]
    wire logic eff_rev = reverse_in ? meas.fwd : meas.rev; // [R09]

    logic [MS_W-1:0] fwd_cnt;
    logic [MS_W-1:0] rev_cnt;

    wire logic fwd_held = eff_fwd && (fwd_cnt >= coord_ms); // [R11]
    wire logic rev_held = eff_rev && (rev_cnt >= coord_ms); // [R11]

    // ****************************************************************
    // permission
    // ****************************************************************
    wire logic sel_fwd  = (torque == TORQUE_FWD); // [R07]
    wire logic sel_rev  = (torque == TORQUE_REV); // [R07]
    // zero torque, unused code 3 or phase inhibit: non-directional
    wire logic open_dir = nondir_in || !(sel_fwd || sel_rev); // [R01] [R06] [R20]

    assign perm_inst  = open_dir || (sel_fwd ? eff_fwd : eff_rev); // [R02] [R12]
    assign perm_timed = open_dir || (sel_fwd ? fwd_held : rev_held); // [R11] [R12]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fwd_cnt <= '0;
            rev_cnt <= '0;
            dir     <= '0;
        end else begin
            if (!eff_fwd) begin
                fwd_cnt <= '0;
            end else if (ms_tick && fwd_cnt != '1) begin
                fwd_cnt <= fwd_cnt + 1'b1;
            end
            if (!eff_rev) begin
                rev_cnt <= '0;
            end else if (ms_tick && rev_cnt != '1) begin
                rev_cnt <= rev_cnt + 1'b1;
            end
            dir <= '{eff_fwd, eff_rev, fwd_held, rev_held}; // [R10]
        end
    end

endmodule
`default_nettype wire

// ### hdl/dos_oc_elem.sv
// one overcurrent element: hysteresis comparator, supervised pickup and
// fixed or inverse timer with trip
// assumes: magnitude and control levels come from logic on hclk
`timescale 1ns/1ps
`default_nettype none
module dos_oc_elem
    import dos_pkg::*;
#(
    parameter bit TIMED = 1'b0
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                ms_tick,
    input  wire logic                enable,
    input  wire logic [MAG_W-1:0]    mag,
    input  wire logic [MAG_W-1:0]    setting,
    input  wire logic [MS_W-1:0]     delay_ms,
    input  wire logic                inverse,
    input  wire logic                perm,
    input  wire logic                annul,
    input  wire logic                bypass,
    output logic                     pickup,
    output logic                     trip
);

    logic                raised;
    logic [MS_W-1:0]     cnt;
    logic [ACC_W-1:0]    acc;

    // ****************************************************************
    // comparator and pickup
    // ****************************************************************
    wire logic [MAG_W:0]   pu_level = {1'b0, setting} + {1'b0, (setting >> PU_SHIFT)};
    wire logic             over_pu  = {1'b0, mag} >= pu_level; // [R16]
    wire logic             under_do = mag < setting; // [R16]
    wire logic             pick     = enable && raised && perm && !annul; // [R02] [R08] [R19]

    // ****************************************************************
    // timing
    // ****************************************************************
    wire logic [ACC_W-1:0] inv_goal = ACC_W'(setting) * ACC_W'(delay_ms); // [R18]
    wire logic             min_ok   = cnt >= MS_W'(MIN_OP_MS); // [R17]
    wire logic             fix_done = (cnt >= delay_ms) && min_ok;
    wire logic             inv_done = (acc >= inv_goal) && min_ok; // [R18]
    wire logic             done     = inverse ? inv_done : fix_done;
    wire logic             bypassed = TIMED && bypass; // [R13]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raised <= 1'b0;
            cnt    <= '0;
            acc    <= '0;
            pickup <= 1'b0;
            trip   <= 1'b0;
        end else begin
            if (!enable) begin
                raised <= 1'b0; // [R19]
            end else if (over_pu) begin
                raised <= 1'b1;
            end else if (under_do) begin
                raised <= 1'b0;
            end
            if (!pick) begin
                cnt <= '0; // [R03] [R04]
                acc <= '0; // [R04]
            end else if (ms_tick) begin
                if (cnt != '1) begin
                    cnt <= cnt + 1'b1;
                end
                if (acc < inv_goal) begin
                    acc <= acc + ACC_W'(mag);
                end
            end
            pickup <= pick;
            trip   <= pick && (bypassed || done); // [R05] [R13]
        end
    end

endmodule
`default_nettype wire

// ### hdl/dos_supervisor.sv
// top: directional supervision of instantaneous and time overcurrent
// elements, settings and status over an AHB-Lite slave
// assumes: sole slave on the bus; measurement and digital inputs on hclk
//
// What this block does
// R01 - directional units supervise when torque is 1 or 2
// R02 - opposite current flow inhibits element pickup
// R03 - inhibited before timing: timer never starts
// R04 - inhibition mid-timing clears; restart from zero
// R05 - trip only after uninterrupted timing
// R06 - torque zero: pickup in either direction
// R07 - torque 1 forward only, 2 reverse only
// R08 - torque annulment input prevents pickup
// R09 - reversal input inverts every unit's direction
// R10 - units give forward/reverse, instantaneous and timed
// R11 - timed outputs delayed by coordination time
// R12 - coordination delay only on directional time elements
// R13 - timer annulment gives immediate permitted trip
// R14 - teleprotection: pickup to send, receive to annul
// R15 - enables per phase/ground/negseq element, plus polchan
// R16 - pickup 1.02-1.08, reset 0.97-1.03 setting
// R17 - zero-delay fixed element trips in 20-25 ms
// R18 - inverse time from dial, setting and current
// R19 - disabled element: no pickup, timing, trip
// R20 - phase inhibit makes phase unit non-directional
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dos_supervisor
    import dos_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic                             hclk,
    input  wire logic                             hresetn,
    input  wire logic                             hsel,
    input  wire logic [31:0]                      haddr,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [31:0]                      hwdata,
    input  wire logic                             hready,
    output logic      [31:0]                      hrdata,
    output logic                                  hreadyout,
    output logic                                  hresp,
    input  wire dos_meas_t [N_UNIT-1:0]           dir_meas,
    input  wire logic [N_ELEM-1:0][MAG_W-1:0]     elem_mag,
    input  wire dos_enables_t                     elem_enables,
    input  wire logic [N_ELEM-1:0]                torque_annul_in,
    input  wire logic [N_ELEM-N_INST-1:0]         timer_annul_in,
    input  wire logic                             trip_direction_reverse_in,
    input  wire logic                             phase_dir_inhibit_in,
    output logic      [N_ELEM-1:0]                elem_pickup,
    output logic      [N_ELEM-1:0]                elem_trip,
    output dos_dir_t  [N_UNIT-1:0]                dir_out
);

    if (TICK_LEN < 1) begin : g_chk
        $error("TICK_LEN must be at least one cycle");
    end

    // ****************************************************************
    // millisecond tick
    // ****************************************************************
    logic [31:0] tick_cnt;
    wire logic   ms_tick = (tick_cnt == 32'(TICK_LEN - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= ms_tick ? '0 : tick_cnt + 1'b1;
        end
    end

    // ****************************************************************
    // settings
    // ****************************************************************
    logic [7:0]            ctrl_torque;
    logic [MS_W-1:0]       coord_ms;
    logic [MAG_W-1:0]      elem_set [N_ELEM];
    logic [16:0]           elem_dly [N_ELEM];

    // ****************************************************************
    // bus slave: address phase capture, data phase write
    // ****************************************************************
    logic        dp_write;
    logic [11:0] dp_addr;

    wire logic        ap_valid  = hsel && hready && htrans[1];
    wire logic [11:0] ap_addr   = {haddr[11:2], 2'b00};
    wire logic        ap_in_set = (ap_addr >= ADDR_SET_BASE) && (ap_addr < ADDR_DLY_BASE);
    wire logic        ap_in_dly = (ap_addr >= ADDR_DLY_BASE)
                                  && (ap_addr < ADDR_DLY_BASE + 12'(4 * N_ELEM));
    wire logic [4:0]  ap_set_i  = 5'((ap_addr - ADDR_SET_BASE) >> 2);
    wire logic [4:0]  ap_dly_i  = 5'((ap_addr - ADDR_DLY_BASE) >> 2);
    wire logic        dp_in_set = (dp_addr >= ADDR_SET_BASE)
                                  && (dp_addr < ADDR_SET_BASE + 12'(4 * N_ELEM));
    wire logic        dp_in_dly = (dp_addr >= ADDR_DLY_BASE)
                                  && (dp_addr < ADDR_DLY_BASE + 12'(4 * N_ELEM));
    wire logic [4:0]  dp_set_i  = 5'((dp_addr - ADDR_SET_BASE) >> 2);
    wire logic [4:0]  dp_dly_i  = 5'((dp_addr - ADDR_DLY_BASE) >> 2);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    logic [31:0] rd_value;
    logic [15:0] dir_flat;

    always_comb begin
        for (int u = 0; u < N_UNIT; u++) begin
            dir_flat[4*u +: 4] = dir_out[u];
        end
    end

    always_comb begin
        rd_value = 32'h00000000;
        if (ap_addr == ADDR_CTRL) begin
            rd_value = {24'h000000, ctrl_torque};
        end else if (ap_addr == ADDR_COORD) begin
            rd_value = {16'h0000, coord_ms};
        end else if (ap_addr == ADDR_PICKUP) begin
            rd_value = {13'h0000, elem_pickup};
        end else if (ap_addr == ADDR_TRIP) begin
            rd_value = {13'h0000, elem_trip};
        end else if (ap_addr == ADDR_DIR) begin
            rd_value = {16'h0000, dir_flat};
        end else if (ap_in_set && ap_set_i < 5'(N_ELEM)) begin
            rd_value = {16'h0000, elem_set[ap_set_i]};
        end else if (ap_in_dly) begin
            rd_value = {15'h0000, elem_dly[ap_dly_i]};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
            hrdata   <= '0;
        end else begin
            dp_write <= ap_valid && hwrite;
            dp_addr  <= ap_addr;
            if (ap_valid && !hwrite) begin
                hrdata <= rd_value;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_torque <= CTRL_RST;
            coord_ms    <= COORD_RST;
            for (int i = 0; i < N_ELEM; i++) begin
                elem_set[i] <= SET_RST;
                elem_dly[i] <= DLY_RST;
            end
        end else if (dp_write) begin
            if (dp_addr == ADDR_CTRL) begin
                ctrl_torque <= hwdata[7:0];
            end
            if (dp_addr == ADDR_COORD) begin
                coord_ms <= hwdata[15:0];
            end
            if (dp_in_set) begin
                elem_set[dp_set_i] <= hwdata[15:0];
            end
            if (dp_in_dly) begin
                elem_dly[dp_dly_i] <= hwdata[16:0];
            end
        end
    end

    // ****************************************************************
    // directional units
    // ****************************************************************
    logic [N_UNIT-1:0] unit_perm_inst;
    logic [N_UNIT-1:0] unit_perm_timed;

    for (genvar u = 0; u < N_UNIT; u++) begin : g_unit
        dos_dir_unit u_unit (
            .hclk       (hclk),
            .hresetn    (hresetn),
            .ms_tick    (ms_tick),
            .torque     (ctrl_torque[TORQUE_W*u +: TORQUE_W]),
            .meas       (dir_meas[u]),
            .reverse_in (trip_direction_reverse_in),
            .nondir_in  ((u == U_PHASE) ? phase_dir_inhibit_in : 1'b0),
            .coord_ms   (coord_ms),
            .dir        (dir_out[u]),
            .perm_inst  (unit_perm_inst[u]),
            .perm_timed (unit_perm_timed[u])
        );
    end

    // ****************************************************************
    // overcurrent elements
    // ****************************************************************
    wire logic [N_ELEM-1:0] enable_vec = elem_enables; // [R15]

    function automatic int unit_of(input int i);
        if (i < 9) begin
            return i / 3;
        end else if (i == 9) begin
            return U_GROUND;
        end else begin
            return (i - N_INST) / 3;
        end
    endfunction

    for (genvar i = 0; i < N_ELEM; i++) begin : g_elem
        localparam bit IS_TIMED = (i >= N_INST);
        wire logic     perm_sel = IS_TIMED ? unit_perm_timed[unit_of(i)]
                                           : unit_perm_inst[unit_of(i)]; // [R10] [R12]
        wire logic     bypass   = IS_TIMED ? timer_annul_in[IS_TIMED ? i - N_INST : 0]
                                           : 1'b0; // [R13] [R14]

        dos_oc_elem #(
            .TIMED (IS_TIMED)
        ) u_elem (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .ms_tick  (ms_tick),
            .enable   (enable_vec[i]),
            .mag      (elem_mag[i]),
            .setting  (elem_set[i]),
            .delay_ms (elem_dly[i][15:0]),
            .inverse  (elem_dly[i][DLY_INV_BIT]),
            .perm     (perm_sel),
            .annul    (torque_annul_in[i]),
            .bypass   (bypass),
            .pickup   (elem_pickup[i]),
            .trip     (elem_trip[i])
        );
    end

endmodule
`default_nettype wire

// ### testbench/dos_supervisor_checker.sv
// checker: gating and timing at supervisor ports
// assumes: bound to dos_supervisor, one hclk domain
`timescale 1ns/1ps
`default_nettype none
module dos_supervisor_checker
    import dos_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic                     hclk,
    input wire logic                     hresetn,
    input wire logic                     hreadyout,
    input wire logic                     hresp,
    input wire dos_meas_t [N_UNIT-1:0]   dir_meas,
    input wire dos_enables_t             elem_enables,
    input wire logic [N_ELEM-1:0]        torque_annul_in,
    input wire logic [N_ELEM-N_INST-1:0] timer_annul_in,
    input wire logic                     trip_direction_reverse_in,
    input wire logic [N_ELEM-1:0]        elem_pickup,
    input wire logic [N_ELEM-1:0]        elem_trip,
    input wire dos_dir_t [N_UNIT-1:0]    dir_out
);
    wire logic [N_ELEM-1:0] en_v = elem_enables;
    int                     pu_cnt;
    // ********
    // pickup run length, element 13
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            pu_cnt <= 0;
        else
            pu_cnt <= elem_pickup[13] ? pu_cnt + 1 : 0;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_gnd_dir(logic rv);
        (dir_meas[1] == 2'b10 && trip_direction_reverse_in == rv) [*2];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    a_dir_fwd: assert property (
        s_gnd_dir(1'b0) |-> dir_out[1].fwd_inst && !dir_out[1].rev_inst)
        else $error("fwd output");
    a_dir_rev: assert property (
        s_gnd_dir(1'b1) |-> dir_out[1].rev_inst && !dir_out[1].fwd_inst)
        else $error("rev output");
    a_dis_pickup: assert property (!en_v[3] |=> !elem_pickup[3])
        else $error("pickup when off");
    a_annul_pickup: assert property (torque_annul_in[13] |=> !elem_pickup[13])
        else $error("pickup annulled");
    a_dis_trip: assert property (!en_v[13] [*3] |-> !elem_trip[13])
        else $error("trip when off");
    a_bypass_trip: assert property (
        elem_pickup[13] && timer_annul_in[3] |=> elem_trip[13] || !elem_pickup[13])
        else $error("no bypass trip");
    a_min_time: assert property (
        $rose(elem_trip[13]) && !$past(timer_annul_in[3]) |-> pu_cnt >= 20 * TICK_LEN)
        else $error("trip too early");
endmodule
`default_nettype wire

// ### testbench/dos_telep.sv
// partner: teleprotection, timed pickups in, receive out
// assumes: send and link_on change just after hclk edges
`timescale 1ns/1ps
`default_nettype none
module dos_telep #(
    parameter int LAT  = 3,
    parameter int HOLD = 40
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       link_on,
    input  wire logic [8:0] send,
    output logic      [8:0] recv
);
    int age [9];
    int idle [9];
    // receive: send held LAT cycles, lingers HOLD
    always @(posedge hclk or negedge hresetn) begin
        for (int i = 0; i < 9; i++) begin
            if (!hresetn || !link_on) begin
                age[i] = 0;
                idle[i] = HOLD;
                recv[i] <= 1'b0;
            end else begin
                age[i] = send[i] ? age[i] + 1 : 0;
                idle[i] = send[i] ? 0 : idle[i] + 1;
                recv[i] <= send[i] ? age[i] >= LAT : recv[i] && idle[i] < HOLD;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_dos_supervisor.sv
// bench: AHB-Lite registers, element stimulus, model compare
// assumes: dos_pkg compiled first; 10-cycle tick
`timescale 1ns/1ps
`default_nettype none
module tb_dos_supervisor;
    import dos_pkg::*;
    localparam int TL = 10;
    `define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
        $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
    logic                         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0]                  haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0]                   htrans = 0;
    logic [2:0]                   hsize = 3'h2;
    logic                         hreadyout, hresp, link_on = 0;
    logic                         trip_direction_reverse_in = 0, phase_dir_inhibit_in = 0;
    dos_meas_t [N_UNIT-1:0]       dir_meas = '0;
    logic [N_ELEM-1:0][MAG_W-1:0] elem_mag = '0;
    dos_enables_t                 elem_enables = '1;
    logic [N_ELEM-1:0]            torque_annul_in = '0, elem_pickup, elem_trip;
    logic [N_ELEM-N_INST-1:0]     timer_annul_in;
    dos_dir_t [N_UNIT-1:0]        dir_out;
    int                           errors = 0, compares = 0, seed = 24;
    always #50 hclk = ~hclk;
    dos_supervisor #(.TICK_LEN(TL)) u_dos_supervisor (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dir_meas,
        .elem_mag, .elem_enables, .torque_annul_in, .timer_annul_in, .trip_direction_reverse_in,
        .phase_dir_inhibit_in, .elem_pickup, .elem_trip, .dir_out);
    dos_telep u_dos_telep (.hclk, .hresetn, .link_on, .send(elem_pickup[N_ELEM-1:N_INST]),
        .recv(timer_annul_in));
    // ********
    // helpers
    // ********
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic op_time(input int e, output int n);
        for (n = 0; elem_pickup[e] !== 1'b1 && n < 50; n++) @(posedge hclk);
        for (n = 0; elem_trip[e] !== 1'b1 && n < 400; n++) @(posedge hclk);
    endtask
    function automatic logic perm(input int tq, input logic f, input logic rv, input logic inh);
        return tq == 0 || tq == 3 || inh || (tq == 1) == (f ^ rv);
    endfunction
    task automatic summarize();
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        errors++;
        summarize();
    end
    initial begin
        logic        f, rv;
        int          n, tq, e;
        int          mt [5] = '{155, 163, 173, 165, 155};
        logic        ex [5] = '{0, 0, 1, 1, 0};
        cyc(16);
        hresetn <= 1'b1;
        bus(1'b0, ADDR_CTRL, 0);
        `CHK("ctrl rst", 32'(CTRL_RST), q)
        bus(1'b0, ADDR_SET_BASE + 12'h014, 0);
        `CHK("set rst", 32'(SET_RST), q)
        bus(1'b0, 12'h040, 0);
        `CHK("unmapped", 32'h0, q)
        wr(ADDR_SET_BASE, 100);
        wr(ADDR_SET_BASE + 12'h00C, 100);
        elem_mag[0] <= 16'd200 + 16'($random(seed) & 32'hFF);
        elem_mag[3] <= 16'd200 + 16'($random(seed) & 32'hFF);
        for (int k = 0; k < 24; k++) begin
            tq = k % 4;
            f = k[2];
            rv = k[3];
            wr(ADDR_CTRL, 32'(tq | (tq << 2)));
            dir_meas[1:0] <= {2{f, !f}};
            trip_direction_reverse_in <= rv;
            phase_dir_inhibit_in <= k >= 16;
            cyc(4);
            `CHK("gnd pu", perm(tq, f, rv, 1'b0), elem_pickup[3])
            `CHK("ph pu", perm(tq, f, rv, k >= 16), elem_pickup[0])
        end
        wr(ADDR_CTRL, 0);
        torque_annul_in[3] <= 1'b1;
        cyc(3);
        `CHK("annul pu", 1'b0, elem_pickup[3])
        torque_annul_in[3] <= 1'b0;
        elem_enables <= '0;
        cyc(4);
        `CHK("off pu", 1'b0, elem_pickup[3])
        elem_enables <= '1;
        wr(ADDR_SET_BASE + 12'h00C, 160);
        for (int k = 0; k < 5; k++) begin
            elem_mag[3] <= 16'(mt[k]);
            cyc(4);
            `CHK("hyst", ex[k], elem_pickup[3])
        end
        for (int k = 0; k < 2; k++) begin
            e = k ? 16 : 13;
            wr(ADDR_SET_BASE + 12'(4 * e), 100);
            wr(ADDR_DLY_BASE + 12'(4 * e), k ? 0 : 30);
            elem_mag[e] <= 16'd300;
            op_time(e, n);
            `CHK("op time", 1'b1, n >= (k ? 20 : 29) * TL && n <= (k ? 25 : 31) * TL)
            elem_mag[e] <= 16'd0;
        end
        torque_annul_in[13] <= 1'b1;
        cyc(1);
        elem_mag[13] <= 16'd300;
        cyc(35 * TL);
        `CHK("held off", 1'b0, elem_trip[13])
        torque_annul_in[13] <= 1'b0;
        cyc(15 * TL);
        torque_annul_in[13] <= 1'b1;
        cyc(5);
        `CHK("cut", 1'b0, elem_trip[13])
        torque_annul_in[13] <= 1'b0;
        op_time(13, n);
        `CHK("restart", 1'b1, n >= 29 * TL && n <= 31 * TL)
        elem_mag[13] <= 16'd0;
        cyc(5);
        link_on <= 1'b1;
        elem_mag[13] <= 16'd300;
        op_time(13, n);
        `CHK("bypass", 1'b1, n <= 8)
        link_on <= 1'b0;
        wr(ADDR_CTRL, 32'h4);
        wr(ADDR_COORD, 5);
        dir_meas[1] <= 2'b01;
        elem_mag[3] <= 16'd300;
        cyc(3);
        dir_meas[1] <= 2'b10;
        cyc(3);
        `CHK("inst free", 1'b1, elem_pickup[3])
        `CHK("tmd held", 1'b0, dir_out[1].fwd_timed)
        `CHK("tmd pu held", 1'b0, elem_pickup[13])
        cyc(6 * TL);
        `CHK("tmd free", 1'b1, dir_out[1].fwd_timed)
        `CHK("tmd pu", 1'b1, elem_pickup[13])
        summarize();
    end
endmodule
bind dos_supervisor dos_supervisor_checker #(.TICK_LEN(TICK_LEN)) u_dos_supervisor_checker (
    .hclk, .hresetn, .hreadyout, .hresp, .dir_meas, .elem_enables, .torque_annul_in,
    .timer_annul_in, .trip_direction_reverse_in, .elem_pickup, .elem_trip, .dir_out);
`default_nettype wire
